// ---- rsps_peripheral_select.sv ----
// Top of the reset strap peripheral select block: captures straps, steers
// shared pins, and holds the software peripheral configuration register.
// Assumes straps are stable around reset release and a simple CPU register port.
//
// Summary of operation
// - Software-writable peripheral configuration register at 0x01B3F000 tunes non-strap selections.
// - PCI and Ethernet select straps captured in reset; live pins ignored.
// - PCI select low enables host port except in MAC-only mode; width and Ethernet straps pick mode.
// - Width/Ethernet pairs: 16-bit, 16-bit plus MAC, 32-bit, MAC only.
// - PCI select high disables host port, MAC, MDIO, upper GPIO; PCI owns pins.
// - With PCI, auto-init strap picks EEPROM load or built-in defaults.
// - Without PCI, upper GPIO works once software sets enable and direction.
// - Without PCI, PCI byte enable and serial PROM select pins float.
// - Timers, I2C and lower GPIO stay available in every configuration.
// - PCI/Ethernet pair decodes: host, Ethernet, PCI, reserved.
`default_nettype none

module rsps_peripheral_select (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Strap pins
  input wire logic pci_select_strap_in,
  input wire logic ethernet_select_strap_in,
  input wire logic host_width_strap_in,
  input wire logic eeprom_autoinit_strap_in,
  input wire logic reserved_low_strap_in,
  // Register port
  input wire logic reg_select_in,
  input wire logic reg_write_in,
  input wire logic [31:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  // Software GPIO settings for upper general purpose pins
  input wire logic [6:0] gpio_enable_bits_in,
  input wire logic [6:0] gpio_direction_bits_in,
  // Peripheral enables
  output logic host_port_enable_out,
  output logic host_port_32bit_out,
  output logic host_low_oe_allow_out,
  output logic host_high_host_out,
  output logic host_high_mac_out,
  output logic ethernet_mac_unit_enable_out,
  output logic pci_enable_out,
  output logic pci_eeprom_autoinit_out,
  output logic pci_only_pins_oe_allow_out,
  output logic [6:0] gpio_upper_enable_out,
  output logic [6:0] gpio_upper_oe_out,
  output logic always_on_enable_out,
  output logic invalid_config_out,
  output logic [26:0] peripheral_config_out
);
  // ------------------------------------------------------------
  // Strap capture
  // ------------------------------------------------------------
  rsps_strap_if straps ();

  rsps_strap_capture u_capture (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .pci_select_strap_in(pci_select_strap_in),
    .ethernet_select_strap_in(ethernet_select_strap_in),
    .host_width_strap_in(host_width_strap_in),
    .eeprom_autoinit_strap_in(eeprom_autoinit_strap_in),
    .reserved_low_strap_in(reserved_low_strap_in),
    .straps(straps)
  );

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  localparam int SW_W = rsps_pkg::SW_FIELD_WIDTH;
  logic captured_reg;
  logic [SW_W-1:0] peripheral_config_reg;
  rsps_pkg::rsps_mode_t mode_next;
  rsps_pkg::rsps_mode_t mode_reg;

  // Decode the captured PCI/Ethernet pair plus width strap into a mode.
  // pair decode
  function automatic rsps_pkg::rsps_mode_t decode_mode(input logic pci, input logic eth,
                                                       input logic wide);
    rsps_pkg::rsps_mode_t m;
    m = rsps_pkg::MODE_HOST16;
    case ({pci, eth})
      rsps_pkg::SEL_HOST: m = wide ? rsps_pkg::MODE_HOST32 : rsps_pkg::MODE_HOST16;
      rsps_pkg::SEL_ETH: m = wide ? rsps_pkg::MODE_ETH_ONLY : rsps_pkg::MODE_HOST16_ETH;
      rsps_pkg::SEL_PCI: m = rsps_pkg::MODE_PCI;
      // Reserved pair: PCI select wins, as for the PCI rows.
      rsps_pkg::SEL_RSVD: m = rsps_pkg::MODE_PCI;
      default: m = rsps_pkg::MODE_HOST16;
    endcase
    return m;
  endfunction

  // Combinational mode from the held straps.
  always_comb begin
    mode_next = decode_mode(straps.pci_select, straps.ethernet_select, straps.host_width);
  end

  // Marks that straps have been captured; steering stays safe before then.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      captured_reg <= 1'b0;
    end else begin
      captured_reg <= 1'b1;
    end
  end

  // Mode register, loaded once after capture and held until next reset.
  // steering held
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_reg <= rsps_pkg::MODE_HOST16;
    end else if (!captured_reg) begin
      mode_reg <= rsps_pkg::MODE_HOST16;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // ------------------------------------------------------------
  // Pin steering
  // ------------------------------------------------------------
  // Steering outputs registered from the held mode. Everything is off in reset.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      host_port_enable_out <= 1'b0;
      host_port_32bit_out <= 1'b0;
      host_low_oe_allow_out <= 1'b0;
      host_high_host_out <= 1'b0;
      host_high_mac_out <= 1'b0;
      ethernet_mac_unit_enable_out <= 1'b0;
      pci_enable_out <= 1'b0;
      pci_eeprom_autoinit_out <= 1'b0;
      pci_only_pins_oe_allow_out <= 1'b0;
      invalid_config_out <= 1'b0;
    end else begin
      host_port_enable_out <= (mode_reg != rsps_pkg::MODE_PCI)
                              && (mode_reg != rsps_pkg::MODE_ETH_ONLY);
      host_port_32bit_out <= (mode_reg == rsps_pkg::MODE_HOST32);
      host_low_oe_allow_out <= (mode_reg == rsps_pkg::MODE_HOST16)
                               || (mode_reg == rsps_pkg::MODE_HOST16_ETH)
                               || (mode_reg == rsps_pkg::MODE_HOST32);
      host_high_host_out <= (mode_reg == rsps_pkg::MODE_HOST32);
      host_high_mac_out <= (mode_reg == rsps_pkg::MODE_HOST16_ETH)
                           || (mode_reg == rsps_pkg::MODE_ETH_ONLY);
      ethernet_mac_unit_enable_out <= (mode_reg == rsps_pkg::MODE_HOST16_ETH)
                                      || (mode_reg == rsps_pkg::MODE_ETH_ONLY);
      pci_enable_out <= (mode_reg == rsps_pkg::MODE_PCI);
      pci_eeprom_autoinit_out <= (mode_reg == rsps_pkg::MODE_PCI) && straps.eeprom_autoinit;
      pci_only_pins_oe_allow_out <= (mode_reg == rsps_pkg::MODE_PCI);
      invalid_config_out <= captured_reg && straps.reserved_high;
    end
  end

  // Upper GPIO follows software enable and direction only without PCI.
  // upper GPIO gated
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gpio_upper_enable_out <= 7'h00;
      gpio_upper_oe_out <= 7'h00;
    end else if (mode_reg == rsps_pkg::MODE_PCI || !captured_reg) begin
      gpio_upper_enable_out <= 7'h00;
      gpio_upper_oe_out <= 7'h00;
    end else begin
      gpio_upper_enable_out <= gpio_enable_bits_in;
      gpio_upper_oe_out <= gpio_enable_bits_in & gpio_direction_bits_in;
    end
  end

  // Timers, I2C and lower GPIO are enabled regardless of strap choice.
  // always available
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      always_on_enable_out <= 1'b0;
    end else begin
      always_on_enable_out <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------
  logic hit;
  assign hit = reg_select_in && (reg_addr_in == rsps_pkg::PERIPHERAL_CONFIG_ADDR);

  // Software configuration field, writable at any time after reset.
  // software config write
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      peripheral_config_reg <= rsps_pkg::PERIPHERAL_CONFIG_RESET[SW_W-1:0];
    end else if (hit && reg_write_in) begin
      peripheral_config_reg <= reg_wdata_in[SW_W-1:0];
    end
  end

  // Drive config to peripherals that are not fixed by straps.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      peripheral_config_out <= rsps_pkg::PERIPHERAL_CONFIG_RESET[SW_W-1:0];
    end else begin
      peripheral_config_out <= peripheral_config_reg;
    end
  end

  // Read data: software field below, captured strap status in the top bits.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (hit && !reg_write_in) begin
      reg_rdata_out <= {straps.pci_select, straps.ethernet_select, straps.host_width,
                        straps.eeprom_autoinit, straps.reserved_high, peripheral_config_reg};
    end else if (reg_select_in && !reg_write_in) begin
      reg_rdata_out <= rsps_pkg::UNMAPPED_READ_VALUE;
    end
  end
endmodule : rsps_peripheral_select

`default_nettype wire

// ---- rsps_pkg.sv ----
// Package of constants for the reset strap peripheral select block.
// Assumes a single device clock and an active-low asynchronous reset.
`default_nettype none

package rsps_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [31:0] PERIPHERAL_CONFIG_ADDR = 32'h01B3F000;
  localparam logic [31:0] PERIPHERAL_CONFIG_RESET = 32'h00000000;
  localparam logic [31:0] UNMAPPED_READ_VALUE = 32'h00000000;
  // Strap pair codes for PCI select and Ethernet select.
  localparam logic [1:0] SEL_HOST = 2'h0;
  localparam logic [1:0] SEL_ETH = 2'h1;
  localparam logic [1:0] SEL_PCI = 2'h2;
  localparam logic [1:0] SEL_RSVD = 2'h3;
  // Field positions of the read-only strap status inside the config word.
  localparam int STAT_PCI_BIT = 31;
  localparam int STAT_ETH_BIT = 30;
  localparam int STAT_WIDTH_BIT = 29;
  localparam int STAT_EEAI_BIT = 28;
  localparam int STAT_INVALID_BIT = 27;
  localparam int SW_FIELD_WIDTH = 27;

  // Pin steering modes.
  typedef enum logic [2:0] {
    MODE_HOST16 = 3'b000,
    MODE_HOST16_ETH = 3'b001,
    MODE_HOST32 = 3'b010,
    MODE_ETH_ONLY = 3'b011,
    MODE_PCI = 3'b100
  } rsps_mode_t;
endpackage : rsps_pkg

`default_nettype wire

// ---- rsps_strap_if.sv ----
// Interface carrying captured strap values between capture and steering.
// Assumes both ends share the device clock.
`default_nettype none

interface rsps_strap_if;
  logic pci_select;
  logic ethernet_select;
  logic host_width;
  logic eeprom_autoinit;
  logic reserved_high;
  modport producer (output pci_select, ethernet_select, host_width, eeprom_autoinit,
                    reserved_high);
  modport consumer (input pci_select, ethernet_select, host_width, eeprom_autoinit,
                    reserved_high);
endinterface : rsps_strap_if

`default_nettype wire

// ---- rsps_strap_capture.sv ----
// Strap capture: latches board straps while device reset is asserted.
// Assumes strap inputs are synchronous to the clock.
`default_nettype none

module rsps_strap_capture (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Strap pins
  input wire logic pci_select_strap_in,
  input wire logic ethernet_select_strap_in,
  input wire logic host_width_strap_in,
  input wire logic eeprom_autoinit_strap_in,
  input wire logic reserved_low_strap_in,
  // Captured values
  rsps_strap_if.producer straps
);
  // Sync reset release into a one-deep history so capture runs during reset.
  logic in_reset_reg;

  // Reset tracking: high while reset is held, falls one edge after release.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      in_reset_reg <= 1'b1;
    end else begin
      in_reset_reg <= 1'b0;
    end
  end

  // Capture straps on the first edge after release, then hold until reset.
  // capture straps
  always_ff @(posedge clock_in) begin
    if (in_reset_reg) begin
      straps.pci_select <= pci_select_strap_in;
      straps.ethernet_select <= ethernet_select_strap_in;
      straps.host_width <= host_width_strap_in;
      straps.eeprom_autoinit <= eeprom_autoinit_strap_in;
      straps.reserved_high <= reserved_low_strap_in;
    end
  end
endmodule : rsps_strap_capture

`default_nettype wire

// ---- rsps_sel_asserts.sv ----
// Concurrent checks on the strap capture, pin steering and register port.
// Assumes it is bound to the block's top module and sees only its ports.
`default_nettype none

module rsps_sel_asserts (
  // Clock, reset, straps and register port
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic pci_select_strap_in,
  input wire logic ethernet_select_strap_in,
  input wire logic host_width_strap_in,
  input wire logic eeprom_autoinit_strap_in,
  input wire logic reserved_low_strap_in,
  input wire logic reg_select_in,
  input wire logic reg_write_in,
  input wire logic [31:0] reg_addr_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic [6:0] gpio_enable_bits_in,
  input wire logic [6:0] gpio_direction_bits_in,
  // Steering outputs
  input wire logic host_port_enable_out,
  input wire logic host_low_oe_allow_out,
  input wire logic host_high_host_out,
  input wire logic host_high_mac_out,
  input wire logic ethernet_mac_unit_enable_out,
  input wire logic pci_enable_out,
  input wire logic pci_eeprom_autoinit_out,
  input wire logic pci_only_pins_oe_allow_out,
  input wire logic [6:0] gpio_upper_oe_out,
  input wire logic always_on_enable_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic armed_reg;
  logic [1:0] age_reg;
  logic [4:0] cap_reg;
  logic [4:0] mode_w;
  logic settled_w;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  // Marks the capture edge and counts edges since release, up to settled.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      armed_reg <= 1'b1;
      age_reg <= 2'h0;
    end else begin
      armed_reg <= 1'b0;
      if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
    end
  end
  // Own copy of the straps as they stood at the capture edge.
  always_ff @(posedge clock_in) begin
    if (armed_reg) cap_reg <= {pci_select_strap_in, ethernet_select_strap_in,
      host_width_strap_in, eeprom_autoinit_strap_in, reserved_low_strap_in};
  end
  // Expected host enable, low half, upper host, upper MAC and MAC enable.
  assign mode_w = cap_reg[4] ? 5'h00 : cap_reg[2] ? (cap_reg[3] ? 5'h03 : 5'h1C) :
    (cap_reg[3] ? 5'h1B : 5'h18);
  assign settled_w = (age_reg == 2'h3);
  AST_STEER: assert property (settled_w |-> {host_port_enable_out,
    host_low_oe_allow_out, host_high_host_out, host_high_mac_out,
    ethernet_mac_unit_enable_out} == mode_w) else $error("host or MAC steering wrong");
  AST_PCI_OWNS: assert property (settled_w |-> pci_enable_out == cap_reg[4] &&
    pci_only_pins_oe_allow_out == cap_reg[4]) else $error("PCI ownership wrong");
  AST_EEPROM: assert property (settled_w |->
    pci_eeprom_autoinit_out == (cap_reg[4] & cap_reg[1])) else $error("autoinit wrong");
  AST_GPIO: assert property (settled_w |=> gpio_upper_oe_out == (cap_reg[4] ? 7'h00 :
    ($past(gpio_enable_bits_in) & $past(gpio_direction_bits_in))))
    else $error("upper GPIO wrong");
  AST_ALWAYS_ON: assert property (settled_w |-> always_on_enable_out)
    else $error("always-on enable low");
  AST_HOLD: assert property (settled_w && $past(settled_w) |-> $stable({pci_enable_out,
    host_port_enable_out, ethernet_mac_unit_enable_out})) else $error("steering moved");
  AST_STATUS_READ: assert property (settled_w && reg_select_in && !reg_write_in &&
    reg_addr_in == rsps_pkg::PERIPHERAL_CONFIG_ADDR |=> reg_rdata_out[31:27] == cap_reg)
    else $error("status bits wrong");
  AST_UNMAPPED: assert property (reg_select_in && !reg_write_in &&
    reg_addr_in != rsps_pkg::PERIPHERAL_CONFIG_ADDR |=>
    reg_rdata_out == rsps_pkg::UNMAPPED_READ_VALUE) else $error("unmapped read not zero");
endmodule // rsps_sel_asserts

bind rsps_peripheral_select rsps_sel_asserts rsps_sel_asserts_inst (.*);

`default_nettype wire

// ---- rsps_strap_board.sv ----
// Board strap resistors: set levels through reset, then the pins carry traffic.
// Assumes the bench's device clock and reset.
`default_nettype none

module rsps_strap_board (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Requested levels and strap pins
  input wire logic [4:0] level_in,
  output logic [4:0] strap_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] hold_reg;
  logic tog_reg = 1'b0;
  // Counts edges since release so the levels stand over the capture edge.
  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) hold_reg <= 2'h0;
    else if (hold_reg != 2'h3) hold_reg <= hold_reg + 2'h1;
  end
  // Toggles mid-cycle so later pin traffic alternates between the inverse of the strap levels and the levels.
  always @(negedge clock_in) tog_reg <= !tog_reg;
  // reserved pin pulled low
  // Bit 0 sits on its pulldown unless a case asks for the faulty level.
  assign strap_out = (hold_reg === 2'h2 || hold_reg === 2'h3) ? ~level_in ^ {5{tog_reg}} :
    level_in;
endmodule // rsps_strap_board

`default_nettype wire

// ---- test_reset_strap_peripheral_select.sv ----
// Bench for the strap select block: every strap set with reserved low, the faulty one, register port, GPIO gating.
// Assumes the board model drives the straps and the checker is bound.
`default_nettype none

module test_reset_strap_peripheral_select;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 1'b0, reset_n_in = 1'b0, reg_select_in = 1'b0, reg_write_in = 1'b0;
  logic [31:0] reg_addr_in = 32'h0, reg_wdata_in = 32'h0, reg_rdata_out;
  logic [6:0] gpio_enable_bits_in = 7'h0, gpio_direction_bits_in = 7'h0;
  logic [6:0] gpio_upper_enable_out, gpio_upper_oe_out;
  logic [26:0] peripheral_config_out;
  logic [4:0] level = 5'h0, strap;
  logic host_port_enable_out, host_port_32bit_out, host_low_oe_allow_out, host_high_host_out;
  logic host_high_mac_out, ethernet_mac_unit_enable_out, pci_enable_out, pci_eeprom_autoinit_out;
  logic pci_only_pins_oe_allow_out, always_on_enable_out, invalid_config_out;
  logic pci_select_strap_in, ethernet_select_strap_in, host_width_strap_in;
  logic eeprom_autoinit_strap_in, reserved_low_strap_in;
  logic [10:0] exp;
  int errors = 0, num_checks = 0;
  // Strap pins come from the board model in pin order.
  assign {pci_select_strap_in, ethernet_select_strap_in, host_width_strap_in,
    eeprom_autoinit_strap_in, reserved_low_strap_in} = strap;
  rsps_strap_board rsps_strap_board_inst (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .level_in(level), .strap_out(strap));
  rsps_peripheral_select rsps_peripheral_select_inst (.*);
  // Free-running 100 MHz clock.
  always #5 clock_in = ~clock_in;
  // Compares one value and counts the outcome.
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    num_checks++;
    if (got !== want) begin
      errors++;
      $display("MISMATCH t=%0t got %h want %h", $time, got, want);
    end
  endtask
  // One register access; the strobe stands over exactly one rising edge.
  task automatic access(input logic wr, input logic [31:0] addr, input logic [31:0] data);
    @(negedge clock_in);
    reg_select_in = 1'b1;
    reg_write_in = wr;
    reg_addr_in = addr;
    reg_wdata_in = data;
    @(negedge clock_in);
    reg_select_in = 1'b0;
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Resets with given strap levels, then checks steering, GPIO and the register.
  task automatic run_case(input logic [4:0] lv);
    @(negedge clock_in);
    level = lv;
    reset_n_in = 1'b0;
    gpio_enable_bits_in = {lv, 2'h3};
    gpio_direction_bits_in = {2'h2, lv};
    repeat (3) @(negedge clock_in);
    reset_n_in = 1'b1;
    repeat (5) @(negedge clock_in);
    exp[10:6] = lv[4] ? 5'h00 : lv[2] ? (lv[3] ? 5'h03 : 5'h1C) : (lv[3] ? 5'h1B : 5'h18);
    exp[5:0] = {lv[4], lv[4] & lv[1], lv[4], ~lv[4] & lv[2] & ~lv[3], 1'b1, lv[0]};
    check({21'h0, host_port_enable_out, host_low_oe_allow_out, host_high_host_out,
      host_high_mac_out, ethernet_mac_unit_enable_out, pci_enable_out, pci_eeprom_autoinit_out,
      pci_only_pins_oe_allow_out, host_port_32bit_out, always_on_enable_out,
      invalid_config_out}, {21'h0, exp});
    check({25'h0, gpio_upper_oe_out}, lv[4] ? 32'h0 :
      {25'h0, gpio_enable_bits_in & gpio_direction_bits_in});
    check({25'h0, gpio_upper_enable_out}, lv[4] ? 32'h0 : {25'h0, gpio_enable_bits_in});
    access(1'b0, rsps_pkg::PERIPHERAL_CONFIG_ADDR, 32'h0);
    check(reg_rdata_out, {lv, rsps_pkg::PERIPHERAL_CONFIG_RESET[26:0]});
    access(1'b1, rsps_pkg::PERIPHERAL_CONFIG_ADDR, 32'hFFFFFFFF);
    access(1'b1, rsps_pkg::PERIPHERAL_CONFIG_ADDR + 32'h4, 32'h0);
    access(1'b0, rsps_pkg::PERIPHERAL_CONFIG_ADDR + 32'h4, 32'h0);
    check(reg_rdata_out, rsps_pkg::UNMAPPED_READ_VALUE);
    access(1'b0, rsps_pkg::PERIPHERAL_CONFIG_ADDR, 32'h0);
    check(reg_rdata_out, {lv, 27'h7FFFFFF});
    check({5'h0, peripheral_config_out}, 32'h07FFFFFF);
  endtask
  // Every strap combination with the reserved pin low, then the faulty high case.
  initial begin
    for (int i = 0; i < 17; i++) begin
      run_case(i < 16 ? {i[3:0], 1'b0} : 5'h01);
      $display("test %0d done", i);
    end
    results();
  end
  // Cuts a hang short well past the few hundred cycles the cases need.
  initial begin
    repeat (5000) @(posedge clock_in);
    errors++;
    results();
  end
endmodule // test_reset_strap_peripheral_select

`default_nettype wire
